// ===== shared/fu_pkg.sv
// constants, field layout and types shared by the float unit issue logic
package fu_pkg;

  // instruction word layout
  localparam int WORD_W = 32;
  localparam int OP_LSB = 28;
  localparam int OP_W = 4;
  localparam int S1_DBL_BIT = 27;
  localparam int S2_DBL_BIT = 26;
  localparam int D_DBL_BIT = 25;
  localparam int DEST_LSB = 16;
  localparam int REG_SEL_W = 5;

  // latencies in clock cycles from issue to writeback
  localparam int ADD_LAT = 5;
  localparam int MUL_LAT = 6;
  localparam int DIV_STEPS = 32;

  // control register file
  localparam int NUM_CREG = 11;
  localparam int NUM_SHADOW = 9;
  localparam logic [3:0] STATUS_IDX = 4'h9;
  localparam logic [3:0] CONTROL_IDX = 4'hA;
  localparam int SH_WORD = 0;
  localparam int SH_OPA = 1;
  localparam int SH_OPB = 2;
  localparam int SH_RESULT = 3;
  localparam int SH_PREC = 4;
  localparam int SH_COUNT = 5;
  localparam int SH_WBREG = 6;
  localparam int SH_DIVQ = 7;
  localparam int SH_SCORE = 8;

  // status bits and rounding field
  localparam int ST_DIVZERO = 0;
  localparam int ST_OVERFLOW = 1;
  localparam int ST_PRIV = 2;
  localparam int ST_ILLEGAL = 3;
  localparam int RND_LSB = 0;
  localparam logic [1:0] RND_UP = 2'h2;
  localparam logic [31:0] STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] CONTROL_RST = 32'h0000_0000;

  typedef enum logic [3:0] {
    OP_INT = 4'h0,
    OP_FADD = 4'h1,
    OP_FSUB = 4'h2,
    OP_FCMP = 4'h3,
    OP_FCVT = 4'h4,
    OP_FMUL = 4'h5,
    OP_FDIV = 4'h6,
    OP_IMUL = 4'h7,
    OP_IDIV = 4'h8
  } op_t;

  // gray codes along idle, run, done
  typedef enum logic [1:0] {
    DV_IDLE = 2'h0,
    DV_RUN = 2'h1,
    DV_DONE = 2'h3
  } div_state_t;

endpackage

// ===== hw/fu_delay_line.sv
// fixed-depth valid/data delay line used as an execution pipeline
`timescale 1ns/1ps
`default_nettype none
module fu_delay_line #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  // stage entry
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  // last stage
  output logic outValid,
  output logic [WIDTH-1:0] outData
);

  if (DEPTH < 1 || WIDTH < 1) begin : g_bad
    $error("fu_delay_line needs DEPTH and WIDTH of at least one");
  end

  logic vld_r [DEPTH];
  logic [WIDTH-1:0] data_r [DEPTH];

  // every stage moves each clock; there is no stall path by design
  for (genvar g = 0; g < DEPTH; g++) begin : g_stage
    logic vldIn;
    logic [WIDTH-1:0] dataIn;
    // stage zero takes the entry, the rest take their predecessor
    if (g == 0) begin : g_head
      assign vldIn = inValid;
      assign dataIn = inData;
    end else begin : g_body
      assign vldIn = vld_r[g-1];
      assign dataIn = data_r[g-1];
    end
    always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
        vld_r[g] <= 1'b0;
        data_r[g] <= '0;
      end else begin
        vld_r[g] <= vldIn;
        data_r[g] <= dataIn;
      end
    end
  end

  assign outValid = vld_r[DEPTH-1];
  assign outData = data_r[DEPTH-1];

endmodule
`default_nettype wire

// ===== hw/fu_iter_divider.sv
// iterative restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none
module fu_iter_divider #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  // request
  input wire logic start,
  input wire logic [WIDTH-1:0] dividend,
  input wire logic [WIDTH-1:0] divisor,
  input wire logic roundUp,
  // result hand-off
  input wire logic grant,
  output logic idleNext,
  output logic done,
  output logic [WIDTH-1:0] quotient,
  output logic divZero
);

  if (WIDTH < 2) begin : g_bad
    $error("fu_iter_divider needs WIDTH of at least two");
  end

  localparam int CNT_W = $clog2(WIDTH);

  fu_pkg::div_state_t state_r;
  logic [WIDTH:0] rem_r;
  logic [WIDTH-1:0] quo_r;
  logic [WIDTH-1:0] dvs_r;
  logic [CNT_W-1:0] cnt_r;
  logic rnd_r;
  logic dz_r;
  logic [WIDTH:0] shifted;
  logic [WIDTH:0] diff;
  logic bump;

  // trial subtraction for the current bit
  assign shifted = {rem_r[WIDTH-1:0], quo_r[WIDTH-1]};
  assign diff = shifted - {1'b0, dvs_r};
  // round toward plus: bump when a remainder is left
  assign bump = rnd_r && (rem_r != '0) && !dz_r;

  // one pass through the same stage per result bit
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= fu_pkg::DV_IDLE;
      rem_r <= '0;
      quo_r <= '0;
      dvs_r <= '0;
      cnt_r <= '0;
      rnd_r <= 1'b0;
      dz_r <= 1'b0;
    end else begin
      case (state_r)
        fu_pkg::DV_IDLE: begin
          if (start) begin
            quo_r <= dividend;
            rem_r <= '0;
            dvs_r <= divisor;
            cnt_r <= '0;
            rnd_r <= roundUp;
            dz_r <= (divisor == '0);
            state_r <= fu_pkg::DV_RUN;
          end
        end
        fu_pkg::DV_RUN: begin
          if (!diff[WIDTH]) begin
            rem_r <= diff;
            quo_r <= {quo_r[WIDTH-2:0], 1'b1};
          end else begin
            rem_r <= shifted;
            quo_r <= {quo_r[WIDTH-2:0], 1'b0};
          end
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r == CNT_W'(WIDTH - 1)) begin
            state_r <= fu_pkg::DV_DONE;
          end
        end
        fu_pkg::DV_DONE: begin
          // result waits here until the destination bus is free
          if (grant) begin
            state_r <= fu_pkg::DV_IDLE;
          end
        end
        default: begin
          state_r <= fu_pkg::DV_IDLE;
        end
      endcase
    end
  end

  assign done = (state_r == fu_pkg::DV_DONE);
  assign idleNext = ((state_r == fu_pkg::DV_IDLE) && !start) || (done && grant);
  assign quotient = quo_r + {{(WIDTH-1){1'b0}}, bump};
  assign divZero = dz_r;

endmodule
`default_nettype wire

// ===== hw/float_unit_pipeline_issue.sv
// float unit issue, pipelines, scoreboard and control registers
`timescale 1ns/1ps
`default_nettype none
module float_unit_pipeline_issue (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // issue from the sequencer
  input wire logic issueValid,
  input wire logic [31:0] issueWord,
  input wire logic [31:0] firstOperandBus,
  input wire logic [31:0] secondOperandBus,
  output logic addPipeReady,
  // routing to the integer unit
  output logic intDispatch,
  output logic [31:0] intWord,
  // destination bus and scoreboard
  output logic destValid,
  output logic [4:0] destReg,
  output logic [31:0] destData,
  output logic [31:0] scoreboard,
  // control register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic regXchg,
  input wire logic regSuper,
  output logic [31:0] regRdData
);

  localparam int ADD_RES_W = fu_pkg::REG_SEL_W + fu_pkg::WORD_W;
  localparam int MUL_RES_W = ADD_RES_W + 1;

  // reset release
  logic rstMeta_r;
  logic rstN_r;

  // decode
  fu_pkg::op_t op;
  logic [4:0] issueDest;
  logic isInt;
  logic isMul;
  logic isDiv;
  logic isAddCls;
  logic intAccept;
  logic mulAccept;
  logic addAccept;
  logic addPipeIn;
  logic divStart;
  logic fpAccept;
  logic illegal;

  // datapath
  logic [31:0] addRes;
  logic [63:0] product;
  logic mulOvf;
  logic addOut;
  logic [ADD_RES_W-1:0] addOutData;
  logic mulOut;
  logic [MUL_RES_W-1:0] mulOutData;
  logic divIdleNext;
  logic divDone;
  logic divGrant;
  logic divZero;
  logic [31:0] divQuot;
  logic [4:0] divDest_r;

  // writeback
  logic wbValid;
  logic [4:0] wbReg;
  logic [31:0] wbData;
  logic ovfWb;
  logic dzWb;

  // state
  logic addReady_r;
  logic intDispatch_r;
  logic [31:0] intWord_r;
  logic destValid_r;
  logic [4:0] destReg_r;
  logic [31:0] destData_r;
  logic [31:0] scoreboard_r;
  logic [31:0] scoreboard_nxt;
  logic [31:0] sbSet;
  logic [31:0] sbClr;

  // registers
  logic [31:0] status_r;
  logic [31:0] control_r;
  logic [31:0] shadow_r [fu_pkg::NUM_SHADOW];
  logic [31:0] statusSet;
  logic [31:0] regRdData_r;
  logic regIdxOk;
  logic isUserReg;
  logic regAllowed;
  logic regAccess;
  logic privFault;
  logic regWrite;
  logic regReadOk;
  logic [31:0] regVal;
  logic [31:0] shadowVal;

  // two-flop reset release so deassertion is clean
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_r <= 1'b0;
      rstN_r <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstN_r <= rstMeta_r;
    end
  end

  // decode straight from the fixed word, in parallel with operand reads
  assign op = fu_pkg::op_t'(issueWord[fu_pkg::OP_LSB +: fu_pkg::OP_W]);
  assign issueDest = issueWord[fu_pkg::DEST_LSB +: fu_pkg::REG_SEL_W];
  assign isInt = (op == fu_pkg::OP_INT);
  assign isMul = (op == fu_pkg::OP_FMUL) || (op == fu_pkg::OP_IMUL);
  assign isDiv = (op == fu_pkg::OP_FDIV) || (op == fu_pkg::OP_IDIV);
  assign isAddCls = isDiv || (op == fu_pkg::OP_FADD) || (op == fu_pkg::OP_FSUB)
                    || (op == fu_pkg::OP_FCMP) || (op == fu_pkg::OP_FCVT);

  // acceptance; multiply is never refused
  assign intAccept = issueValid && isInt;
  assign mulAccept = issueValid && isMul;
  assign addAccept = issueValid && isAddCls && addReady_r;
  assign addPipeIn = addAccept && !isDiv;
  assign divStart = addAccept && isDiv;
  assign fpAccept = mulAccept || addAccept;
  assign illegal = issueValid && !(isInt || isMul || isAddCls);

  // stand-in arithmetic on the low word; precision tags travel in the shadows
  assign addRes = (op == fu_pkg::OP_FSUB) ? firstOperandBus - secondOperandBus :
                  (op == fu_pkg::OP_FCMP) ? {29'h0000_0000,
                    firstOperandBus < secondOperandBus,
                    firstOperandBus == secondOperandBus,
                    firstOperandBus > secondOperandBus} :
                  (op == fu_pkg::OP_FCVT) ? firstOperandBus :
                  firstOperandBus + secondOperandBus;
  assign product = firstOperandBus * secondOperandBus;
  assign mulOvf = |product[63:32];

  // add/sub/compare/convert pipeline
  fu_delay_line #(
    .WIDTH(ADD_RES_W),
    .DEPTH(fu_pkg::ADD_LAT - 1)
  ) addPipe (
    .clk(core_clk),
    .rstN(rstN_r),
    .inValid(addPipeIn),
    .inData({issueDest, addRes}),
    .outValid(addOut),
    .outData(addOutData)
  );

  // free-running multiply pipeline, no stall input at all
  fu_delay_line #(
    .WIDTH(MUL_RES_W),
    .DEPTH(fu_pkg::MUL_LAT - 1)
  ) mulPipe (
    .clk(core_clk),
    .rstN(rstN_r),
    .inValid(mulAccept),
    .inData({issueDest, mulOvf, product[31:0]}),
    .outValid(mulOut),
    .outData(mulOutData)
  );

  // divide iterates in its own unit, outside the add pipeline; add class issue waits while it runs
  fu_iter_divider #(
    .WIDTH(fu_pkg::DIV_STEPS)
  ) divUnit (
    .clk(core_clk),
    .rstN(rstN_r),
    .start(divStart),
    .dividend(firstOperandBus),
    .divisor(secondOperandBus),
    .roundUp(control_r[fu_pkg::RND_LSB +: 2] == fu_pkg::RND_UP),
    .grant(divGrant),
    .idleNext(divIdleNext),
    .done(divDone),
    .quotient(divQuot),
    .divZero(divZero)
  );

  // one destination bus: the pipelines never collide, divide waits its turn
  assign divGrant = divDone && !mulOut && !addOut;
  assign wbValid = mulOut || addOut || divGrant;
  assign wbReg = mulOut ? mulOutData[MUL_RES_W-1 -: 5] :
                 addOut ? addOutData[ADD_RES_W-1 -: 5] : divDest_r;
  assign wbData = mulOut ? mulOutData[31:0] :
                  addOut ? addOutData[31:0] : divQuot;
  assign ovfWb = mulOut && mulOutData[32];
  assign dzWb = divGrant && divZero;

  // scoreboard: set wins over clear, register zero never marked
  assign sbSet = fpAccept ? (32'h0000_0001 << issueDest) : 32'h0000_0000;
  assign sbClr = wbValid ? (32'h0000_0001 << wbReg) : 32'h0000_0000;
  assign scoreboard_nxt = ((scoreboard_r & ~sbClr) | sbSet) & 32'hFFFF_FFFE;

  // add class is refused one cycle after a multiply so results never meet
  always_ff @(posedge core_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      addReady_r <= 1'b1;
      divDest_r <= 5'h00;
    end else begin
      addReady_r <= !mulAccept && divIdleNext;
      if (divStart) begin
        divDest_r <= issueDest;
      end
    end
  end

  // integer work goes to the integer unit for one cycle
  always_ff @(posedge core_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      intDispatch_r <= 1'b0;
      intWord_r <= 32'h0000_0000;
    end else begin
      intDispatch_r <= intAccept;
      if (intAccept) begin
        intWord_r <= issueWord;
      end
    end
  end

  // destination bus and scoreboard registers
  always_ff @(posedge core_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      destValid_r <= 1'b0;
      destReg_r <= 5'h00;
      destData_r <= 32'h0000_0000;
      scoreboard_r <= 32'h0000_0000;
    end else begin
      destValid_r <= wbValid;
      destReg_r <= wbReg;
      destData_r <= wbData;
      scoreboard_r <= scoreboard_nxt;
    end
  end

  // register access: user mode sees only status and control
  assign regIdxOk = (regAddr < 4'(fu_pkg::NUM_CREG));
  assign isUserReg = (regAddr == fu_pkg::STATUS_IDX) || (regAddr == fu_pkg::CONTROL_IDX);
  assign regAllowed = regIdxOk && (regSuper || isUserReg);
  assign regAccess = regRd || regWr || regXchg;
  assign privFault = regAccess && regIdxOk && !regAllowed;
  assign regWrite = (regWr || regXchg) && regAllowed;
  assign regReadOk = (regRd || regXchg) && regAllowed;
  assign shadowVal = (regAddr < 4'(fu_pkg::NUM_SHADOW)) ? shadow_r[regAddr] : 32'h0000_0000;
  assign regVal = (regAddr == fu_pkg::STATUS_IDX) ? status_r :
                  (regAddr == fu_pkg::CONTROL_IDX) ? control_r : shadowVal;

  // sticky exception bits; hardware set beats a software write
  assign statusSet = ({31'h0000_0000, dzWb} << fu_pkg::ST_DIVZERO)
                   | ({31'h0000_0000, ovfWb} << fu_pkg::ST_OVERFLOW)
                   | ({31'h0000_0000, privFault} << fu_pkg::ST_PRIV)
                   | ({31'h0000_0000, illegal} << fu_pkg::ST_ILLEGAL);

  // status, control and read data; exchange returns the old value
  always_ff @(posedge core_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      status_r <= fu_pkg::STATUS_RST;
      control_r <= fu_pkg::CONTROL_RST;
      regRdData_r <= 32'h0000_0000;
    end else begin
      if (regWrite && regAddr == fu_pkg::STATUS_IDX) begin
        status_r <= regWrData | statusSet;
      end else begin
        status_r <= status_r | statusSet;
      end
      if (regWrite && regAddr == fu_pkg::CONTROL_IDX) begin
        control_r <= regWrData;
      end
      regRdData_r <= regReadOk ? regVal : 32'h0000_0000;
    end
  end

  // shadow state for recovery; a hardware capture overrides a restore write
  always_ff @(posedge core_clk or negedge rstN_r) begin
    if (!rstN_r) begin
      for (int i = 0; i < fu_pkg::NUM_SHADOW; i++) begin
        shadow_r[i] <= 32'h0000_0000;
      end
    end else begin
      for (int i = 0; i < fu_pkg::NUM_SHADOW; i++) begin
        if (regWrite && regAddr == 4'(i)) begin
          shadow_r[i] <= regWrData;
        end
      end
      if (fpAccept) begin
        shadow_r[fu_pkg::SH_WORD] <= issueWord;
        shadow_r[fu_pkg::SH_OPA] <= firstOperandBus;
        shadow_r[fu_pkg::SH_OPB] <= secondOperandBus;
        shadow_r[fu_pkg::SH_PREC] <= {29'h0000_0000,
          issueWord[fu_pkg::S1_DBL_BIT],
          issueWord[fu_pkg::S2_DBL_BIT],
          issueWord[fu_pkg::D_DBL_BIT]};
        shadow_r[fu_pkg::SH_COUNT] <= shadow_r[fu_pkg::SH_COUNT] + 32'h0000_0001;
      end
      if (wbValid) begin
        shadow_r[fu_pkg::SH_RESULT] <= wbData;
        shadow_r[fu_pkg::SH_WBREG] <= {27'h000_0000, wbReg};
      end
      if (divDone) begin
        shadow_r[fu_pkg::SH_DIVQ] <= divQuot;
      end
      shadow_r[fu_pkg::SH_SCORE] <= scoreboard_r;
    end
  end

  // outputs straight from flops
  assign addPipeReady = addReady_r;
  assign intDispatch = intDispatch_r;
  assign intWord = intWord_r;
  assign destValid = destValid_r;
  assign destReg = destReg_r;
  assign destData = destData_r;
  assign scoreboard = scoreboard_r;
  assign regRdData = regRdData_r;

  // checks on timing, scoreboard and access control
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstN_r);

  a_add_latency: assert property (
    addPipeIn |-> ##5 (destValid_r && destReg_r == $past(issueDest, 5)))
    else $error("add class result not on the bus five cycles after issue");

  a_mul_latency: assert property (
    mulAccept |-> ##6 (destValid_r && destData_r == $past(product[31:0], 6)))
    else $error("multiply result not on the bus six cycles after issue");

  a_mul_stream: assert property (
    mulAccept ##1 mulAccept |-> ##5 destValid_r ##1 destValid_r)
    else $error("back to back multiplies did not retire back to back");

  a_mul_free_run: assert property (
    (mulAccept && !divIdleNext) |-> ##6 (destValid_r && destReg_r == $past(issueDest, 6)))
    else $error("multiply pipeline held back by the divider");

  a_div_iterate: assert property (
    divStart |=> !divDone [*8] ##25 divDone)
    else $error("divide did not take one pass per result bit");

  a_sb_set: assert property (
    (fpAccept && issueDest != 5'h00) |=> scoreboard_r[$past(issueDest)])
    else $error("destination not marked busy after issue");

  a_sb_clear: assert property (
    (destValid_r && !($past(fpAccept) && $past(issueDest) == destReg_r))
    |-> !scoreboard_r[destReg_r])
    else $error("scoreboard bit still set in its writeback cycle");

  a_zero_reg: assert property (
    !scoreboard_r[0])
    else $error("register zero marked busy");

  a_int_route: assert property (
    intAccept |=> (intDispatch_r && intWord_r == $past(issueWord)
      && (scoreboard_r & ~$past(scoreboard_r)) == 32'h0000_0000))
    else $error("integer instruction not routed out");

  a_priv_block: assert property (
    (regRd && !regSuper && regAddr < 4'(fu_pkg::NUM_SHADOW))
    |=> (regRdData_r == 32'h0000_0000 && status_r[fu_pkg::ST_PRIV]))
    else $error("user read of a privileged register not blocked");

  a_user_status: assert property (
    (regRd && regAddr == fu_pkg::STATUS_IDX) |=> regRdData_r == $past(status_r))
    else $error("status register not readable");

  a_xchg_ctrl: assert property (
    (regXchg && regAddr == fu_pkg::CONTROL_IDX)
    |=> (regRdData_r == $past(control_r) && control_r == $past(regWrData)))
    else $error("control exchange did not swap");

  c_mul_stream: cover property (mulAccept [*3]);
  c_div_retire: cover property (divGrant && divZero);
  c_add_after_div: cover property (divGrant ##1 addPipeIn);
  c_priv_fault: cover property (privFault ##1 regXchg);

endmodule
`default_nettype wire

// ===== tb/fu_seq_model.sv
// sequencer partner: register file, scoreboard hold and forwarding
`timescale 1ns/1ps
`default_nettype none
module fu_seq_model (
  // writeback side
  input wire logic core_clk,
  input wire logic destValid,
  input wire logic [4:0] destReg,
  input wire logic [31:0] destData,
  input wire logic [31:0] scoreboard,
  // operand lookup
  input wire logic [4:0] rdSel,
  output logic [31:0] rdData,
  output logic rdBusy
);
  logic [31:0] gpr [32];
  // results land in the file; register zero is never written
  always_ff @(posedge core_clk) begin
    if (destValid && destReg != 5'h00) gpr[destReg] <= destData;
  end
  // forwarding hands a waiting unit the bus value in the update cycle
  assign rdData = (rdSel == 5'h00) ? 32'h0 : (destValid && destReg == rdSel) ? destData : gpr[rdSel];
  // hold while busy; register zero never stalls anyone
  assign rdBusy = (rdSel != 5'h00) && scoreboard[rdSel];
endmodule
`default_nettype wire

// ===== tb/float_unit_pipeline_issue_bench.sv
// self-checking bench for the float unit issue block
`timescale 1ns/1ps
`default_nettype none
module float_unit_pipeline_issue_bench;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic issueValid = 1'h0;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic regXchg = 1'h0;
  logic regSuper = 1'h0;
  logic [31:0] issueWord = 32'h0;
  logic [31:0] opA = 32'h0;
  logic [31:0] opB = 32'h0;
  logic [31:0] regWrData = 32'h0;
  logic [3:0] regAddr = 4'h0;
  logic [4:0] rdSel = 5'h03;
  logic addPipeReady, intDispatch, destValid, rdBusy;
  logic [4:0] destReg;
  logic [31:0] intWord, destData, scoreboard, regRdData, rdData;
  int errorCnt = 0;
  int compares = 0;
  int n;

  float_unit_pipeline_issue dut (.core_clk(core_clk), .rst_n(rst_n), .issueValid(issueValid),
    .issueWord(issueWord), .firstOperandBus(opA), .secondOperandBus(opB), .addPipeReady(addPipeReady),
    .intDispatch(intDispatch), .intWord(intWord), .destValid(destValid), .destReg(destReg),
    .destData(destData), .scoreboard(scoreboard), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regXchg(regXchg), .regSuper(regSuper), .regRdData(regRdData));
  fu_seq_model seq (.core_clk(core_clk), .destValid(destValid), .destReg(destReg), .destData(destData),
    .scoreboard(scoreboard), .rdSel(rdSel), .rdData(rdData), .rdBusy(rdBusy));

  // 40 MHz clock
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] mk(input logic [3:0] op, input logic [4:0] d);
    return {op, 7'h00, d, 16'h0000};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errorCnt++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one instruction per edge; back-to-back calls keep issueValid up
  task automatic issue(input logic [3:0] op, input logic [4:0] d, input logic [31:0] a, input logic [31:0] b);
    issueValid <= 1'h1;
    issueWord <= mk(op, d);
    opA <= a;
    opB <= b;
    @(posedge core_clk);
  endtask

  // waits for a writeback, exactly k cycles away when k is nonzero
  task automatic wb(input int k, input logic [4:0] d, input logic [31:0] v, input bit dat);
    int i;
    i = 0;
    issueValid <= 1'h0;
    while (i < 40) begin
      @(posedge core_clk);
      #1;
      i++;
      if (i == 1 && k > 1) chk(scoreboard[d], d != 5'h00);
      if (destValid === 1'h1) break;
    end
    if (k > 0) chk(i, k);
    chk(destReg, d);
    if (dat) chk(destData, v);
    chk(scoreboard[d], 1'h0);
  endtask

  // register port access: 0 write, 1 read, 2 exchange
  task automatic acc(input int k, input logic [3:0] a, input logic [31:0] d, input logic s, input logic [31:0] exp);
    regWr <= (k == 0);
    regRd <= (k == 1);
    regXchg <= (k == 2);
    regAddr <= a;
    regWrData <= d;
    regSuper <= s;
    @(posedge core_clk);
    regWr <= 1'h0;
    regRd <= 1'h0;
    regXchg <= 1'h0;
    #1;
    if (k > 0) chk(regRdData, exp);
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, errorCnt);
    if (errorCnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog: the tests need a few hundred cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    errorCnt++;
    end_of_test();
  end

  // test sequence
  initial begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (3) @(posedge core_clk);
    #1;
    chk({29'h0, addPipeReady, destValid, intDispatch}, 32'h4);
    chk(scoreboard, 32'h0);
    acc(1, 4'h9, 0, 0, 0);
    acc(1, 4'h0, 0, 0, 0);
    acc(1, 4'h9, 0, 0, 32'h4);
    acc(0, 4'h9, 0, 0, 0);
    acc(1, 4'hF, 0, 1, 0);
    acc(2, 4'hA, 32'h2, 1, 0);
    acc(1, 4'hA, 0, 0, 32'h2);
    $display("test 1 done");
    // add class back to back, one per clock
    for (int k = 1; k < 5; k++) issue(4'(k), 5'(10 + k), 32'h9, 32'h4);
    wb(1, 5'h0B, 32'hD, 1);
    wb(1, 5'h0C, 32'h5, 1);
    wb(1, 5'h0D, 32'h1, 1);
    wb(1, 5'h0E, 32'h9, 1);
    // the add right after a multiply is dropped
    issue(4'h5, 5'h04, 32'h7, 32'h3);
    issue(4'h1, 5'h08, 32'h1, 32'h1);
    issue(4'h1, 5'h09, 32'h2, 32'h2);
    wb(3, 5'h04, 32'h15, 1);
    wb(1, 5'h09, 32'h4, 1);
    chk(scoreboard, 0);
    issue(4'h7, 5'h05, 32'h6, 32'h7);
    wb(5, 5'h05, 32'h2A, 1);
    $display("test 2 done");
    issue(4'h0, 5'h02, 0, 0);
    issueValid <= 1'h0;
    #1;
    chk(intDispatch, 1);
    chk(intWord, mk(4'h0, 5'h02));
    chk(scoreboard, 0);
    @(posedge core_clk);
    #1;
    chk(intDispatch, 0);
    $display("test 3 done");
    // multiply keeps going while the divider iterates; rounding is up until control is written to zero
    issue(4'h6, 5'h07, 32'h64, 32'h7);
    issue(4'h5, 5'h08, 32'h3, 32'h3);
    wb(5, 5'h08, 32'h9, 1);
    wb(0, 5'h07, 32'hF, 1);
    issue(4'h8, 5'h0A, 32'h15, 32'h7);
    wb(33, 5'h0A, 32'h3, 1);
    acc(0, 4'hA, 0, 1, 0);
    issue(4'h6, 5'h07, 32'h64, 32'h7);
    wb(33, 5'h07, 32'hE, 1);
    issue(4'h6, 5'h09, 32'h5, 32'h0);
    wb(33, 5'h09, 32'hFFFFFFFF, 1);
    acc(1, 4'h0, 0, 1, mk(4'h6, 5'h09));
    $display("test 4 done");
    // zero register, then a dependent add fed by forwarding
    issue(4'h1, 5'h00, 32'h1, 32'h1);
    wb(4, 5'h00, 32'h2, 1);
    issue(4'h1, 5'h03, 32'h14, 32'h16);
    issueValid <= 1'h0;
    @(posedge core_clk);
    #1;
    n = 1;
    while (rdBusy === 1'h1 && n < 9) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(n, 4);
    chk(rdData, 32'h2A);
    issue(4'h1, 5'h06, rdData, 32'h1);
    wb(4, 5'h06, 32'h2B, 1);
    $display("test 5 done");
    // sticky status: divide by zero, overflow, illegal op
    issue(4'h5, 5'h0C, 32'h10000, 32'h10000);
    issue(4'h5, 5'h0E, 32'h2, 32'h3);
    wb(4, 5'h0C, 0, 1);
    wb(1, 5'h0E, 32'h6, 1);
    issue(4'h9, 5'h0D, 0, 0);
    issueValid <= 1'h0;
    acc(0, 4'hA, 0, 1, 0);
    acc(1, 4'h9, 0, 1, 32'hB);
    $display("test 6 done");
    end_of_test();
  end
endmodule
`default_nettype wire
